// ==== hdl/tcp_pkg.sv ====
// package: register map, field positions, reset values and timing for the 8-bit timer/counter
package tcp_pkg;

  // register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] TCP_COUNT_OFS   = 8'h00;
  localparam logic [7:0] TCP_OPTION_OFS  = 8'h04;
  localparam logic [7:0] TCP_INTCTL_OFS  = 8'h08;
  localparam logic [7:0] TCP_STATUS_OFS  = 8'h0C;

  // option register fields
  localparam int TCP_OPT_CS_BIT      = 5;
  localparam int TCP_OPT_SE_BIT      = 4;
  localparam int TCP_OPT_ASSIGN_BIT  = 3;
  localparam int TCP_OPT_PS_MSB      = 2;
  localparam int TCP_OPT_PS_LSB      = 0;
  localparam logic [5:0] TCP_OPTION_RST = 6'h3F;

  // interrupt control register fields
  localparam int TCP_INT_EN_BIT   = 5;
  localparam int TCP_INT_FLAG_BIT = 2;

  // reset values
  localparam logic [7:0] TCP_COUNT_RST = 8'h00;
  localparam logic [7:0] TCP_PRESC_RST = 8'h00;

  // instruction cycle: four phase clocks of the core clock
  localparam int          TCP_PHASES      = 4;
  localparam logic [1:0]  TCP_PH_Q1       = 2'h0;
  localparam logic [1:0]  TCP_PH_Q2       = 2'h1;
  localparam logic [1:0]  TCP_PH_Q3       = 2'h2;
  localparam logic [1:0]  TCP_PH_Q4       = 2'h3;

  // counting held off for this many instruction cycles after a count write
  localparam logic [1:0]  TCP_WR_INHIBIT  = 2'h2;

  // AXI responses
  localparam logic [1:0]  TCP_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  TCP_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TCP_SRC_INSTR,
    TCP_SRC_EXT
  } tcp_src_t;

endpackage

// ==== hdl/tcp_timer.sv ====
// 8-bit timer/counter with shared prescaler, watchdog hand-off and AXI4-Lite registers
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module tcp_timer
  import tcp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pin and core-side signals
  input  wire logic        external_count_input,
  input  wire logic        sleep_mode,
  input  wire logic        watchdog_clear_instruction,
  input  wire logic        watchdog_tick_in,
  output logic             watchdog_tick_out,
  output logic             irq
);

  // instruction-cycle phase divider
  logic [1:0] phase_reg;
  logic       instr_tick;
  logic       sample_phase;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      phase_reg <= TCP_PH_Q1;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign instr_tick   = (phase_reg == TCP_PH_Q4);
  assign sample_phase = (phase_reg == TCP_PH_Q2) || (phase_reg == TCP_PH_Q4);

  // registers
  logic [7:0] count_reg;
  logic [5:0] option_reg;
  logic       overflow_flag_reg;
  logic       overflow_enable_reg;
  logic [1:0] inhibit_reg;
  logic [7:0] presc_reg;

  logic       clock_source_select;
  logic       source_edge_select;
  logic       prescaler_assignment;
  logic [2:0] prescale_ratio_field;

  assign clock_source_select  = option_reg[TCP_OPT_CS_BIT];
  assign source_edge_select   = option_reg[TCP_OPT_SE_BIT];
  assign prescaler_assignment = option_reg[TCP_OPT_ASSIGN_BIT];
  assign prescale_ratio_field = option_reg[TCP_OPT_PS_MSB:TCP_OPT_PS_LSB];

  // external pin synchroniser and edge select
  logic ext_meta_reg;
  logic ext_sync_reg;
  logic ext_prev_reg;
  logic ext_edge;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_meta_reg <= external_count_input;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  // rising when select is zero, falling when one
  assign ext_edge = source_edge_select ? (ext_prev_reg && !ext_sync_reg)
                                       : (!ext_prev_reg && ext_sync_reg);

  // source selection
  tcp_src_t src_sel;
  logic     src_event;

  assign src_sel   = clock_source_select ? TCP_SRC_EXT : TCP_SRC_INSTR;
  assign src_event = (src_sel == TCP_SRC_EXT) ? ext_edge : instr_tick;

  // bus decode (write side)
  logic       aw_hold_reg;
  logic [7:0] aw_addr_reg;
  logic       w_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic       wr_fire;
  logic       wr_count;
  logic       wr_option;
  logic       wr_intctl;
  logic       wr_mapped;

  assign wr_fire   = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign wr_count  = wr_fire && (aw_addr_reg == TCP_COUNT_OFS) && w_strb_reg[0];
  assign wr_option = wr_fire && (aw_addr_reg == TCP_OPTION_OFS) && w_strb_reg[0];
  assign wr_intctl = wr_fire && (aw_addr_reg == TCP_INTCTL_OFS) && w_strb_reg[0];
  assign wr_mapped = (aw_addr_reg == TCP_COUNT_OFS) || (aw_addr_reg == TCP_OPTION_OFS) ||
                     (aw_addr_reg == TCP_INTCTL_OFS) || (aw_addr_reg == TCP_STATUS_OFS);

  // shared prescaler
  // the pin is resynchronised before division too, because no logic may see the raw pin;
  // the divided output is then sampled again on Q2/Q4, which caps external rate at core_clk/2
  logic       presc_step;
  logic       presc_clear;
  logic       presc_tap;
  logic [7:0] presc_mask;
  logic       presc_pend_reg;
  logic       timer_inc;

  // counter ratio 2^(n+1); watchdog ratio 2^n so its 1:1 setting is reachable
  always_comb begin
    presc_mask = 8'h00;
    if (!prescaler_assignment) begin
      presc_mask = 8'(9'h002 << prescale_ratio_field) - 8'h01;
    end else begin
      presc_mask = 8'(9'h001 << prescale_ratio_field) - 8'h01;
    end
  end

  assign presc_step  = prescaler_assignment ? watchdog_tick_in : (src_event && !sleep_mode);
  assign presc_clear = (wr_count && !prescaler_assignment) ||
                       (watchdog_clear_instruction && prescaler_assignment);
  assign presc_tap   = presc_step && ((presc_reg & presc_mask) == presc_mask);

  // internal count only; no bus path reads or loads it
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      presc_reg <= TCP_PRESC_RST;
    end else if (presc_clear) begin
      presc_reg <= TCP_PRESC_RST;
    end else if (presc_step) begin
      presc_reg <= presc_reg + 8'h01;
    end
  end

  assign watchdog_tick_out = prescaler_assignment && presc_tap;

  // counter-side division: straight 1:1 when assigned to the watchdog, else prescaler output
  logic div_out;
  assign div_out = prescaler_assignment ? (src_event && !sleep_mode) : presc_tap;

  // resynchronise the divided output to Q2/Q4 sample points
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      presc_pend_reg <= 1'b0;
    end else if (sleep_mode || wr_count) begin
      presc_pend_reg <= 1'b0;
    end else if (div_out) begin
      presc_pend_reg <= 1'b1;
    end else if (sample_phase) begin
      presc_pend_reg <= 1'b0;
    end
  end

  assign timer_inc = presc_pend_reg && sample_phase && !sleep_mode && (inhibit_reg == 2'h0);

  // write inhibit
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      inhibit_reg <= 2'h0;
    end else if (wr_count) begin
      inhibit_reg <= TCP_WR_INHIBIT;
    end else if (instr_tick && (inhibit_reg != 2'h0)) begin
      inhibit_reg <= inhibit_reg - 2'h1;
    end
  end

  // count register
  logic overflow_event;
  assign overflow_event = timer_inc && (count_reg == 8'hFF) && !wr_count;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      count_reg <= TCP_COUNT_RST;
    end else if (wr_count) begin
      count_reg <= w_data_reg[7:0];
    end else if (timer_inc) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // option register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      option_reg <= TCP_OPTION_RST;
    end else if (wr_option) begin
      option_reg <= w_data_reg[5:0];
    end
  end

  // read side
  logic        rd_status;
  logic [31:0] rd_data_next;
  logic        rd_ok_next;

  // same word decode as the read mux, so any byte address of the word clears
  assign rd_status = s_axi_arvalid && s_axi_arready && ({s_axi_araddr[7:2], 2'h0} == TCP_STATUS_OFS);

  // interrupt control
  // a set in the same cycle as a clear wins, so no overflow is lost
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      overflow_flag_reg <= 1'b0;
    end else if (overflow_event) begin
      overflow_flag_reg <= 1'b1;
    end else if (wr_intctl && !w_data_reg[TCP_INT_FLAG_BIT]) begin
      overflow_flag_reg <= 1'b0;
    end else if (rd_status) begin
      overflow_flag_reg <= 1'b0;
    end else if (wr_intctl) begin
      overflow_flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      overflow_enable_reg <= 1'b0;
    end else if (wr_intctl) begin
      overflow_enable_reg <= w_data_reg[TCP_INT_EN_BIT];
    end
  end

  assign irq = overflow_flag_reg && overflow_enable_reg;

  // AXI4-Lite write channel
  // no new write is taken while its answer still waits for bready
  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
    end else if (wr_fire) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= TCP_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? TCP_RESP_OKAY : TCP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_data_next = 32'h0000_0000;
    rd_ok_next   = 1'b1;
    case ({s_axi_araddr[7:2], 2'h0})
      TCP_COUNT_OFS: begin
        rd_data_next[7:0] = count_reg;
      end
      TCP_OPTION_OFS: begin
        rd_data_next[5:0] = option_reg;
      end
      TCP_INTCTL_OFS: begin
        rd_data_next[TCP_INT_EN_BIT]   = overflow_enable_reg;
        rd_data_next[TCP_INT_FLAG_BIT] = overflow_flag_reg;
      end
      TCP_STATUS_OFS: begin
        rd_data_next[TCP_INT_FLAG_BIT] = overflow_flag_reg;
      end
      default: begin
        rd_ok_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= TCP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data_next;
      s_axi_rresp  <= rd_ok_next ? TCP_RESP_OKAY : TCP_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== tb/tcp_ext_src.sv ====
// external clock source model driving the count input pin
`timescale 1ns/100ps
`default_nettype none
module tcp_ext_src (
  output var logic pin
);
  initial pin = 1'b0;
  // caller keeps half periods above two core clocks, the pin is resynchronised before the prescaler
  task automatic toggle(input int n, input int half);
    repeat (n) begin
      #(half) pin <= ~pin;
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/tcp_timer_asserts.sv ====
// checker: bus handshake, irq and watchdog tick relations at the timer ports
`timescale 1ns/100ps
`default_nettype none
module tcp_timer_asserts (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        sleep_mode,
  input wire logic        watchdog_tick_in,
  input wire logic        watchdog_tick_out,
  input wire logic        irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  chk_tick_gated: assert property (watchdog_tick_out |-> watchdog_tick_in)
    else $error("watchdog tick without source");
  // irq may only fall as a consequence of a register access
  chk_irq_sticky: assert property ($fell(irq) |-> s_axi_rvalid || s_axi_bvalid || $past(s_axi_rvalid) || $past(s_axi_bvalid))
    else $error("irq fell by itself");
  chk_sleep_quiet: assert property (sleep_mode && $past(sleep_mode) && !s_axi_bvalid |-> !$rose(irq))
    else $error("irq rose in sleep");
endmodule
bind tcp_timer tcp_timer_asserts i_tcp_timer_asserts (
  .core_clk          (core_clk),
  .rstn              (rstn),
  .s_axi_awvalid     (s_axi_awvalid),
  .s_axi_awready     (s_axi_awready),
  .s_axi_wvalid      (s_axi_wvalid),
  .s_axi_wready      (s_axi_wready),
  .s_axi_bvalid      (s_axi_bvalid),
  .s_axi_bready      (s_axi_bready),
  .s_axi_arvalid     (s_axi_arvalid),
  .s_axi_arready     (s_axi_arready),
  .s_axi_rdata       (s_axi_rdata),
  .s_axi_rvalid      (s_axi_rvalid),
  .s_axi_rready      (s_axi_rready),
  .sleep_mode        (sleep_mode),
  .watchdog_tick_in  (watchdog_tick_in),
  .watchdog_tick_out (watchdog_tick_out),
  .irq               (irq)
);
`default_nettype wire

// ==== tb/testbench.sv ====
// bench: bus tasks, integer expectations and scenarios for the timer/counter
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tcp_pkg::*;
  logic        core_clk = 1'b0, rstn = 1'b0, sleep_mode = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        watchdog_clear_instruction = 1'b0, watchdog_tick_in = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, v, got, seed = 32'h2A;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  rsp;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic   external_count_input, watchdog_tick_out, irq;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int          n_fail = 0, checks = 0, n_watchdog_ticks = 0;

  tcp_timer i_tcp_timer (
    .core_clk                   (core_clk),
    .rstn                       (rstn),
    .s_axi_awaddr               (s_axi_awaddr),
    .s_axi_awvalid              (s_axi_awvalid),
    .s_axi_awready              (s_axi_awready),
    .s_axi_wdata                (s_axi_wdata),
    .s_axi_wstrb                (s_axi_wstrb),
    .s_axi_wvalid               (s_axi_wvalid),
    .s_axi_wready               (s_axi_wready),
    .s_axi_bresp                (s_axi_bresp),
    .s_axi_bvalid               (s_axi_bvalid),
    .s_axi_bready               (s_axi_bready),
    .s_axi_araddr               (s_axi_araddr),
    .s_axi_arvalid              (s_axi_arvalid),
    .s_axi_arready              (s_axi_arready),
    .s_axi_rdata                (s_axi_rdata),
    .s_axi_rresp                (s_axi_rresp),
    .s_axi_rvalid               (s_axi_rvalid),
    .s_axi_rready               (s_axi_rready),
    .external_count_input       (external_count_input),
    .sleep_mode                 (sleep_mode),
    .watchdog_clear_instruction (watchdog_clear_instruction),
    .watchdog_tick_in           (watchdog_tick_in),
    .watchdog_tick_out          (watchdog_tick_out),
    .irq                        (irq)
  );
  tcp_ext_src i_tcp_ext_src (.pin(external_count_input));

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (watchdog_tick_out === 1'b1) n_watchdog_ticks++;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin @(posedge core_clk iff s_axi_awready); s_axi_awvalid <= 1'b0; end
      begin @(posedge core_clk iff s_axi_wready); s_axi_wvalid <= 1'b0; end
    join
    // late bready lets the held answer be seen standing
    repeat (2) @(posedge core_clk);
    s_axi_bready <= 1'b1;
    @(posedge core_clk iff s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(posedge core_clk iff s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge core_clk);
    s_axi_rready <= 1'b1;
    @(posedge core_clk iff s_axi_rvalid);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic tick(input int n, input bit clr);
    repeat (n) begin
      @(posedge core_clk);
      if (clr) watchdog_clear_instruction <= 1'b1;
      else watchdog_tick_in <= 1'b1;
      @(posedge core_clk);
      watchdog_clear_instruction <= 1'b0;
      watchdog_tick_in <= 1'b0;
    end
    #1;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    rd(TCP_OPTION_OFS, got);
    check("option", got, 32'h3F);
    rd(TCP_COUNT_OFS, got);
    check("count", got, 32'h0);
    wr(8'h10, 32'h0);
    check("bresp", rsp, TCP_RESP_SLVERR);
    rd(8'h10, got);
    check("rresp", rsp, TCP_RESP_SLVERR);
    check("unmapped data", got, 32'h0);
    $display("test reset done");
    for (int n = 0; n < 8; n++) begin
      wr(TCP_OPTION_OFS, 32'h20 | n);
      // one stray edge left in the prescaler; the count write must discard it
      i_tcp_ext_src.toggle(2, 30);
      v = rnd() & 32'h7F;
      wr(TCP_COUNT_OFS, v);
      repeat (10) @(posedge core_clk);
      i_tcp_ext_src.toggle((12 << n) - 2, 30);
      repeat (20) @(posedge core_clk);
      rd(TCP_COUNT_OFS, got);
      check("prescaled count", got, v + 2);
    end
    for (int se = 1; se >= 0; se--) begin
      wr(TCP_OPTION_OFS, 32'h28 | (se << 4));
      wr(TCP_COUNT_OFS, 32'h0);
      repeat (10) @(posedge core_clk);
      for (int k = 0; k < 2; k++) begin
        i_tcp_ext_src.toggle(1, 30);
        repeat (20) @(posedge core_clk);
        rd(TCP_COUNT_OFS, got);
        check("edge count", got, (k == 1 || se == 0) ? 1 : 0);
      end
    end
    $display("test counter mode done");
    wr(TCP_OPTION_OFS, 32'h08);
    check("bresp okay", rsp, TCP_RESP_OKAY);
    wr(TCP_COUNT_OFS, 32'h0);
    repeat (37) @(posedge core_clk);
    rd(TCP_COUNT_OFS, got);
    check("timer rate", got >= 8 && got <= 9, 1);
    wr(TCP_INTCTL_OFS, 32'h20);
    wr(TCP_COUNT_OFS, 32'hFE);
    repeat (30) @(posedge core_clk);
    check("irq", irq, 1);
    rd(TCP_STATUS_OFS, got);
    check("status", got, 32'h04);
    @(posedge core_clk);
    check("irq after read", irq, 0);
    wr(TCP_INTCTL_OFS, 32'h00);
    wr(TCP_COUNT_OFS, 32'hFE);
    repeat (30) @(posedge core_clk);
    check("masked irq", irq, 0);
    rd(TCP_INTCTL_OFS, got);
    check("masked flag", got, 32'h04);
    wr(TCP_INTCTL_OFS, 32'h20);
    check("irq reenabled", irq, 0);
    sleep_mode <= 1'b1;
    rd(TCP_COUNT_OFS, v);
    repeat (40) @(posedge core_clk);
    rd(TCP_COUNT_OFS, got);
    check("sleep hold", got, v);
    sleep_mode <= 1'b0;
    $display("test timer mode done");
    wr(TCP_OPTION_OFS, 32'h0A);
    tick(1, 1);
    tick(3, 0);
    tick(1, 1);
    tick(3, 0);
    check("watchdog ticks", n_watchdog_ticks, 0);
    tick(1, 0);
    check("watchdog ticks", n_watchdog_ticks, 1);
    wr(TCP_OPTION_OFS, 32'h02);
    tick(8, 0);
    check("watchdog ticks", n_watchdog_ticks, 1);
    $display("test watchdog done");
    tally_and_finish();
  end

  // run needs roughly 100 us; a hang past four times this span (400 us) is a failure
  initial begin
    #400000;
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
